// file: flash_seq_consts.svh
// Constants of the self-programming flash sequencer
`ifndef FLASH_SEQ_CONSTS_SVH
`define FLASH_SEQ_CONSTS_SVH
`define CTRL_ADDR 4'h0
`define PTR_LO_ADDR 4'h1
`define PTR_HI_ADDR 4'h2
`define DATA_LO_ADDR 4'h3
`define DATA_HI_ADDR 4'h4
`define FUSE_LO_ADDR 4'h5
`define FUSE_HI_ADDR 4'h6
`define LOCK_ADDR 4'h7
`define STAT_ADDR 4'h8
`define BUF_DATA_ADDR 4'h9
`define CMD_MASK 5'h1f
`define CMD_LOAD 5'h01
`define CMD_ERASE 5'h03
`define CMD_WRITE 5'h05
`define CMD_LOCK 5'h09
`define CMD_RWW_EN 5'h11
`define BIT_IRQ_EN 7
`define BIT_BUSY 6
`define STORE_WINDOW 3'h4
`define LOAD_WINDOW 3'h3
`define PROG_TIME_US 3700
`define CLK_MHZ 50
`define LOCK_RESET 8'hff
`define FUSE_LO_RESET 8'he1
`define FUSE_HI_RESET 8'hd9
`define RWW_LAST_PAGE 7'h5f
`define LOCK_PTR 16'h0001
`define FUSE_LO_PTR 16'h0000
`define FUSE_HI_PTR 16'h0003
`endif

// file: flash_seq_pkg.sv
// Types of the self-programming flash sequencer
package flash_seq_pkg;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ARMED = 2'b01,
    ST_PROG = 2'b10
  } seq_state_t;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

  typedef struct packed {
    seq_state_t st;
    logic [4:0] cmd;
    logic irq_en;
    logic busy;
    logic [2:0] win;
    logic [22:0] cnt;
    logic [1:0] op;
    logic [15:0] ptr;
    logic [15:0] data;
    logic [7:0] lock;
    logic [7:0] rdata;
    logic [7:0] lpm_data;
    logic lpm_valid;
    logic [6:0] page;
    logic [4:0] word_sel;
    logic [31:0] loaded;
    logic ee_q1;
    logic ee_q2;
    logic prog_req;
    logic erase_req;
    logic [6:0] prog_page;
  } seq_regs_t;
endpackage : flash_seq_pkg

// file: flash_seq.sv
// Self-programming flash sequencer: control register, page buffer and timed operations
// How it works
// - Buffer words load in any order
// - Erase pattern then store within four cycles
// - Erasing the no-read-while-write section halts CPU
// - Load pattern stores data word at pointer
// - Buffer clears after write, enable, reset
// - EEPROM write during loading discards buffer
// - Write pattern then store programs buffered page
// - Writing no-read-while-write section halts CPU
// - Ready interrupt level while store enable clear
// - Busy flag blocks section reads during programming
// - Lock pattern then store sets lock bits
// - Cleared data bits 5..2 program lock bits
// - Lock programming blocks no flash reads
// - EEPROM write blocks commands and readback
// - Armed load at pointer one reads locks
// - Lock and enable clear on completion, timeout
// - Pointers zero and three read fuse bytes
// - Programmed bits read zero, unprogrammed one
// - Reset does not abort a running write
// - Store enable armed four cycles, held while programming
// - Undefined control patterns have no effect
// - Page from pointer 12..6, word 5..1
// - Busy flag clears when loading starts
//
// Decided for this implementation: strobed register access and the register offsets.
`timescale 1ns/10ps
`include "flash_seq_consts.svh"
module flash_seq
  import flash_seq_pkg::*;
#(
  parameter logic [22:0] PROG_CYCLES = 23'(`PROG_TIME_US * `CLK_MHZ)
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic store_instr,
  input wire logic load_instr,
  input wire logic eeprom_write_busy,
  output logic [7:0] lpm_data,
  output logic lpm_valid,
  output logic cpu_halt,
  output logic section_busy_flag,
  output logic ready_irq,
  output logic [6:0] prog_page,
  output logic erase_start,
  output logic write_start,
  output logic [15:0] page_buf_word
);
  seq_regs_t r, nxt;
  reg_req_t req;
  logic [15:0] buf_mem [0:31];
  logic buf_we;
  logic clear_buf;
  logic store_enable_bit;
  logic cmd_ok;
  logic [4:0] wr_cmd;

  assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};
  assign store_enable_bit = (r.st != ST_IDLE);
  assign wr_cmd = req.wdata[4:0] & `CMD_MASK;
  assign cmd_ok = (wr_cmd == `CMD_LOAD) || (wr_cmd == `CMD_ERASE) || (wr_cmd == `CMD_WRITE) ||
                  (wr_cmd == `CMD_LOCK) || (wr_cmd == `CMD_RWW_EN);

  always_comb begin
    nxt = r;
    buf_we = 1'b0;
    clear_buf = 1'b0;
    nxt.lpm_valid = 1'b0;
    nxt.prog_req = 1'b0;
    nxt.erase_req = 1'b0;
    nxt.ee_q1 = eeprom_write_busy;
    nxt.ee_q2 = r.ee_q1;
    nxt.rdata = 8'h00;
    if (req.wr) begin
      unique case (req.addr)
        `PTR_LO_ADDR: nxt.ptr[7:0] = req.wdata;
        `PTR_HI_ADDR: nxt.ptr[15:8] = req.wdata;
        `DATA_LO_ADDR: nxt.data[7:0] = req.wdata;
        `DATA_HI_ADDR: nxt.data[15:8] = req.wdata;
        `CTRL_ADDR: begin
          nxt.irq_en = req.wdata[`BIT_IRQ_EN];
          // Commands ignored while programming or EEPROM busy
          if (r.st == ST_IDLE && cmd_ok && !r.ee_q2) begin
            nxt.st = ST_ARMED;
            nxt.cmd = wr_cmd;
            nxt.win = 3'h0;
          end
        end
        default: ;
      endcase
    end
    if (req.rd) begin
      unique case (req.addr)
        `CTRL_ADDR: nxt.rdata = {r.irq_en, r.busy, 1'b0, r.cmd[4:1] & {4{store_enable_bit}},
                                 store_enable_bit};
        `PTR_LO_ADDR: nxt.rdata = r.ptr[7:0];
        `PTR_HI_ADDR: nxt.rdata = r.ptr[15:8];
        `DATA_LO_ADDR: nxt.rdata = r.data[7:0];
        `DATA_HI_ADDR: nxt.rdata = r.data[15:8];
        `LOCK_ADDR: nxt.rdata = r.lock;
        `STAT_ADDR: nxt.rdata = {6'h00, r.st};
        default: nxt.rdata = 8'h00;
      endcase
    end
    // EEPROM write mid-load loses the loaded words
    if (r.ee_q2 && (|r.loaded)) begin
      clear_buf = 1'b1;
    end
    unique case (r.st)
      ST_IDLE: ;
      ST_ARMED: begin
        nxt.win = r.win + 3'h1;
        if (store_instr) begin
          unique case (r.cmd)
            `CMD_LOAD: begin
              buf_we = 1'b1;
              nxt.word_sel = r.ptr[5:1];
              nxt.busy = 1'b0;
              nxt.st = ST_IDLE;
            end
            `CMD_ERASE, `CMD_WRITE: begin
              nxt.page = r.ptr[12:6];
              nxt.op = (r.cmd == `CMD_ERASE) ? 2'h1 : 2'h2;
              nxt.erase_req = (r.cmd == `CMD_ERASE);
              nxt.prog_req = (r.cmd == `CMD_WRITE);
              nxt.busy = (r.ptr[12:6] <= `RWW_LAST_PAGE);
              nxt.cnt = PROG_CYCLES;
              nxt.st = ST_PROG;
            end
            `CMD_LOCK: begin
              // Only cleared bits program; a full reset sets them back to all ones
              nxt.lock = r.lock & {2'b11, r.data[5:2], 2'b11};
              nxt.op = 2'h3;
              nxt.cnt = PROG_CYCLES;
              nxt.st = ST_PROG;
            end
            default: begin
              nxt.busy = 1'b0;
              clear_buf = 1'b1;
              nxt.st = ST_IDLE;
            end
          endcase
        end else if (load_instr && r.cmd == `CMD_LOCK && r.win < `LOAD_WINDOW && !r.ee_q2) begin
          nxt.lpm_valid = 1'b1;
          nxt.lpm_data = (r.ptr == `LOCK_PTR) ? r.lock :
                         (r.ptr == `FUSE_LO_PTR) ? `FUSE_LO_RESET :
                         (r.ptr == `FUSE_HI_PTR) ? `FUSE_HI_RESET : 8'hff;
          nxt.st = ST_IDLE;
        end else if (r.win + 3'h1 >= `STORE_WINDOW) begin
          nxt.st = ST_IDLE;
        end
      end
      ST_PROG: begin
        nxt.cnt = r.cnt - 23'h1;
        if (r.cnt == 23'h1) begin
          nxt.st = ST_IDLE;
          if (r.op == 2'h2) begin
            clear_buf = 1'b1;
          end
          nxt.op = 2'h0;
        end
      end
      default: nxt.st = ST_IDLE;
    endcase
    if (buf_we) begin
      nxt.loaded[r.ptr[5:1]] = 1'b1;
    end
    if (clear_buf) begin
      nxt.loaded = 32'h0;
    end
  end

  always_ff @(posedge clk) begin
    // A running erase or write keeps going through reset
    // Unknown state at power-up must fall into the full reset branch
    if (!rst_n && r.st == ST_PROG) begin
      r.cnt <= r.cnt - 23'h1;
      r.st <= (r.cnt == 23'h1) ? ST_IDLE : ST_PROG;
      r.irq_en <= 1'b0;
      r.loaded <= 32'h0;
      r.erase_req <= 1'b0;
      r.prog_req <= 1'b0;
      r.lpm_valid <= 1'b0;
      r.rdata <= 8'h00;
    end else if (!rst_n) begin
      r <= '0;
      r.lock <= `LOCK_RESET;
      r.loaded <= 32'h0;
    end else begin
      r <= nxt;
    end
  end

  // Buffer contents qualified by the loaded mask, no reset needed on the array
  always_ff @(posedge clk) begin
    if (buf_we) begin
      buf_mem[r.ptr[5:1]] <= r.data;
    end
    page_buf_word <= r.loaded[r.ptr[5:1]] ? buf_mem[r.ptr[5:1]] : 16'hffff;
  end

  assign reg_rdata = r.rdata;
  assign lpm_data = r.lpm_data;
  assign lpm_valid = r.lpm_valid;
  assign cpu_halt = (r.st == ST_PROG) && (r.op != 2'h3) && !r.busy;
  assign section_busy_flag = r.busy;
  assign ready_irq = r.irq_en && !store_enable_bit;
  assign prog_page = r.page;
  assign erase_start = r.erase_req;
  assign write_start = r.prog_req;
endmodule : flash_seq

// file: flash_seq_assertions.sv
// Checker for the flash sequencer ports
`timescale 1ns/10ps
module flash_seq_assertions (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic store_instr,
  input wire logic load_instr,
  input wire logic eeprom_write_busy,
  input wire logic lpm_valid,
  input wire logic cpu_halt,
  input wire logic section_busy_flag,
  input wire logic ready_irq,
  input wire logic [6:0] prog_page,
  input wire logic erase_start,
  input wire logic write_start
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_start;
    erase_start || write_start;
  endsequence
  sequence s_rww_start;
    s_start ##1 (prog_page <= 7'h5f);
  endsequence
  a_start_cause: assert property (s_start |-> $past(store_instr))
    else $error("start without store");
  a_start_gap: assert property (s_start |=> !(erase_start || write_start) [*8])
    else $error("start too soon");
  a_halt_match: assert property (s_start |=> cpu_halt == (prog_page > 7'h5f))
    else $error("halt mismatch");
  a_busy_set: assert property (s_rww_start |-> section_busy_flag)
    else $error("busy not set");
  // Reset also drops the flag, so that cause is allowed
  a_busy_clear: assert property ($fell(section_busy_flag) |-> $past(store_instr) || !$past(rst_n))
    else $error("busy cleared alone");
  a_lpm_cause: assert property ($rose(lpm_valid) |-> $past(load_instr))
    else $error("readback without load");
  a_lpm_pulse: assert property (lpm_valid |=> !lpm_valid)
    else $error("readback too long");
  a_ee_block: assert property (eeprom_write_busy [*4] |-> !(erase_start || write_start || lpm_valid))
    else $error("action while eeprom busy");
  a_irq_quiet: assert property (s_start |=> !ready_irq [*4])
    else $error("irq while programming");
endmodule : flash_seq_assertions

// file: cpu_model.sv
// CPU model: one store or load a set number of cycles after a command write
`timescale 1ns/10ps
module cpu_model (
  input wire logic clk,
  input wire logic go,
  input wire logic is_load,
  input wire logic [2:0] dly,
  output logic store_instr,
  output logic load_instr
);
  logic [3:0] cnt_r = 4'h0;
  always @(posedge clk) begin
    if (go) begin
      cnt_r <= {1'b0, dly} + 4'h1;
    end else if (cnt_r != 4'h0) begin
      cnt_r <= cnt_r - 4'h1;
    end
  end
  // Delay 0 to 3 stays inside the store window (0 to 2 for a load), 7 misses it on purpose
  assign store_instr = cnt_r == 4'h1 && !is_load;
  assign load_instr = cnt_r == 4'h1 && is_load;
endmodule : cpu_model

// file: self_program_flash_sequencer_tb_top.sv
// Bench: register tasks, readback table, then hand tests
`timescale 1ns/10ps
`include "flash_seq_consts.svh"
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin \
  miscompares++; $display("[ERR] %0t got %h exp %h", $time, a, b); end end
module self_program_flash_sequencer_tb_top;
  logic clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, ld = 1'b0;
  logic eeprom_write_busy = 1'b0;
  logic [2:0] dly = 3'h0;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] reg_rdata, lpm_data, rv, got;
  logic store_instr, load_instr, lpm_valid, cpu_halt, section_busy_flag, ready_irq;
  logic erase_start, write_start;
  logic [6:0] prog_page;
  logic [15:0] page_buf_word;
  int miscompares = 0;
  int samples_checked = 0;
  logic [23:0] rows [3] = '{{16'h0000, `FUSE_LO_RESET}, {16'h0001, `LOCK_RESET},
    {16'h0003, `FUSE_HI_RESET}};
  always #10 clk = ~clk;
  always @(posedge clk) if (lpm_valid) got <= lpm_data;
  // Short programming time keeps the run small
  flash_seq #(.PROG_CYCLES(23'd10)) uut (.*);
  cpu_model cpu (.go(reg_wr && reg_addr == `CTRL_ADDR), .is_load(ld), .*);
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : wt
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(posedge clk);
  endtask : wr
  task automatic rd(input logic [3:0] a);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 rv = reg_rdata;
    @(posedge clk);
  endtask : rd
  task automatic cmd(input logic [15:0] p, input logic [7:0] c, input logic [2:0] d, input logic l);
    wr(`PTR_LO_ADDR, p[7:0]);
    wr(`PTR_HI_ADDR, p[15:8]);
    dly <= d;
    ld <= l;
    wr(`CTRL_ADDR, c);
    wt(5);
  endtask : cmd
  task automatic give_verdict();
    $display("checked %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : give_verdict
  initial begin
    wt(3);
    rst_n <= 1'b1;
    wt(1);
    rd(`CTRL_ADDR);
    `CHK(rv, 8'h00)
    rd(`LOCK_ADDR);
    `CHK(rv, `LOCK_RESET)
    foreach (rows[i]) begin
      got = 8'h5a;
      cmd(rows[i][23:8], 8'h09, 3'd2, 1'b1);
      `CHK(got, rows[i][7:0])
      rd(`CTRL_ADDR);
      `CHK(rv, 8'h00)
    end
    eeprom_write_busy <= 1'b1;
    got = 8'h5a;
    wt(3);
    cmd(16'h0001, 8'h09, 3'd2, 1'b1);
    `CHK(got, 8'h5a)
    eeprom_write_busy <= 1'b0;
    wt(3);
    cmd(16'h0080, 8'h83, 3'd3, 1'b0);
    `CHK(section_busy_flag, 1'b1)
    `CHK(cpu_halt, 1'b0)
    `CHK(ready_irq, 1'b0)
    wt(12);
    `CHK(ready_irq, 1'b1)
    rd(`CTRL_ADDR);
    `CHK(rv, 8'hc0)
    wr(`DATA_LO_ADDR, 8'h34);
    wr(`DATA_HI_ADDR, 8'h12);
    cmd(16'h0006, 8'h01, 3'd0, 1'b0);
    `CHK(page_buf_word, 16'h1234)
    rd(`CTRL_ADDR);
    `CHK(rv, 8'h00)
    cmd(16'h1800, 8'h03, 3'd0, 1'b0);
    `CHK(cpu_halt, 1'b1)
    wt(12);
    wr(`DATA_LO_ADDR, 8'hcd);
    wr(`DATA_HI_ADDR, 8'hab);
    cmd(16'h0002, 8'h01, 3'd2, 1'b0);
    `CHK(page_buf_word, 16'habcd)
    cmd(16'h0080, 8'h03, 3'd0, 1'b0);
    wt(12);
    `CHK(section_busy_flag, 1'b1)
    cmd(16'h0002, 8'h11, 3'd0, 1'b0);
    `CHK(section_busy_flag, 1'b0)
    `CHK(page_buf_word, 16'hffff)
    cmd(16'h1800, 8'h05, 3'd1, 1'b0);
    `CHK(cpu_halt, 1'b1)
    wt(12);
    cmd(16'h0006, 8'h07, 3'd0, 1'b0);
    rd(`STAT_ADDR);
    `CHK(rv, 8'h00)
    `CHK(page_buf_word, 16'hffff)
    wr(`DATA_LO_ADDR, 8'hc3);
    cmd(16'h0001, 8'h09, 3'd1, 1'b0);
    `CHK(section_busy_flag, 1'b0)
    wt(12);
    rd(`LOCK_ADDR);
    `CHK(rv, 8'hc3)
    cmd(16'h0000, 8'h09, 3'd7, 1'b0);
    rd(`CTRL_ADDR);
    `CHK(rv, 8'h00)
    // Reset in the middle of an erase: erase runs on, buffer is lost
    wr(`DATA_LO_ADDR, 8'h11);
    cmd(16'h0006, 8'h01, 3'd0, 1'b0);
    cmd(16'h0080, 8'h03, 3'd0, 1'b0);
    rst_n <= 1'b0;
    wt(2);
    rst_n <= 1'b1;
    rd(`STAT_ADDR);
    `CHK(rv, 8'h02)
    `CHK(page_buf_word, 16'hffff)
    wt(5);
    give_verdict();
  end
  initial begin
    #20us;
    miscompares++;
    give_verdict();
  end
endmodule : self_program_flash_sequencer_tb_top
bind flash_seq flash_seq_assertions chk (.*);
